// ==== qdc_serial_load.sv ====
`timescale 1ns/100ps
module qdc_serial_load (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic chipSelectN,
  input wire logic serialClock,
  input wire logic serialInPowerDownPin,
  input wire logic serialPinFloating,
  input wire logic dacLoadStrobeN,
  input wire logic registerClearN,
  output qdc_pkg::qdc_codes_t dacCode,
  output logic [qdc_pkg::CHAN_COUNT-1:0] channelOutEnable,
  output logic hardwarePowerDown
);
  import qdc_pkg::*;

  qdc_pins_t pinMeta;
  qdc_pins_t pinSync;
  qdc_pins_t pinPrev;
  qdc_pins_t next_pinMeta;
  qdc_pins_t next_pinSync;
  qdc_pins_t next_pinPrev;

  qdc_word_t shiftWord;
  qdc_word_t next_shiftWord;

  qdc_codes_t inputReg;
  qdc_codes_t next_inputReg;
  qdc_codes_t next_dacCode;
  logic [CHAN_COUNT-1:0] chanOff;
  logic [CHAN_COUNT-1:0] next_chanOff;
  logic [CHAN_COUNT-1:0] next_channelOutEnable;
  logic next_hardwarePowerDown;

  logic clockRise;
  logic csRise;
  qdc_addr_t wordAddr;

  // Every pin is asynchronous to ref_clk, so all of them pass two flops first.
  always_comb
  begin
    next_pinMeta.chipSelectN = chipSelectN;
    next_pinMeta.serialClock = serialClock;
    next_pinMeta.serialData = serialInPowerDownPin;
    next_pinMeta.pinFloating = serialPinFloating;
    next_pinMeta.loadStrobeN = dacLoadStrobeN;
    next_pinMeta.clearN = registerClearN;
    next_pinSync = pinMeta;
    next_pinPrev = pinSync;
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pinMeta <= PINS_IDLE;
      pinSync <= PINS_IDLE;
      pinPrev <= PINS_IDLE;
    end
    else
    begin
      pinMeta <= next_pinMeta;
      pinSync <= next_pinSync;
      pinPrev <= next_pinPrev;
    end
  end

  assign clockRise = pinSync.serialClock && !pinPrev.serialClock;
  assign csRise = pinSync.chipSelectN && !pinPrev.chipSelectN;
  assign wordAddr = {shiftWord.channelSelectHi, shiftWord.channelSelectLo};

  // Bits are shifted in at the low end, so the oldest bit leaves the top. A word longer
  // than twelve bits therefore keeps only its last twelve. A floating pin carries no data,
  // so no bit is taken while it floats.
  always_comb
  begin
    next_shiftWord = shiftWord;
    if (!pinSync.chipSelectN && clockRise && !pinSync.pinFloating)
    begin
      next_shiftWord = {shiftWord[WORD_W-2:0], pinSync.serialData};
    end
  end

  // The shift register has no clear term beside reset.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      shiftWord <= SHIFT_RESET;
    end
    else
    begin
      shiftWord <= next_shiftWord;
    end
  end

  always_comb
  begin
    next_inputReg = inputReg;
    next_chanOff = chanOff;
    if (csRise)
    begin
      for (int i = 0; i < CHAN_COUNT; i++)
      begin
        if (chanHit(wordAddr, i))
        begin
          next_inputReg[i] = shiftWord.data;
        end
        next_chanOff[i] = (shiftWord.allChannelOffBit == OFF_ACTIVE) ||
          ((shiftWord.oneChannelOffBit == OFF_ACTIVE) && chanHit(wordAddr, i));
      end
    end
    if (!pinSync.clearN)
    begin
      next_inputReg = ZERO_CODES;
    end

    // The strobe looks at no chip select term, and the DAC registers take the input
    // registers' new value so a strobe held low tracks each new load at once.
    next_dacCode = dacCode;
    if (!pinSync.loadStrobeN)
    begin
      next_dacCode = next_inputReg;
    end
    if (!pinSync.clearN)
    begin
      next_dacCode = ZERO_CODES;
    end

    // Power down only gates the drivers; codes are kept untouched.
    next_hardwarePowerDown = pinSync.pinFloating;
    next_channelOutEnable = next_hardwarePowerDown ? NO_CHANNELS : ~next_chanOff;
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      inputReg <= ZERO_CODES;
      dacCode <= ZERO_CODES;
      chanOff <= NO_CHANNELS;
      channelOutEnable <= ALL_CHANNELS;
      hardwarePowerDown <= 1'b0;
    end
    else
    begin
      inputReg <= next_inputReg;
      dacCode <= next_dacCode;
      chanOff <= next_chanOff;
      channelOutEnable <= next_channelOutEnable;
      hardwarePowerDown <= next_hardwarePowerDown;
    end
  end

endmodule

// ==== qdc_pkg.sv ====
// How it works
// - A low load strobe copies all four input registers into the DAC registers together.
// - The load strobe is a level; while low the DAC registers follow the input registers.
// - A low clear input forces all input and DAC registers to zero code.
// - Clear never touches the serial shift register.
// - Serial clock edges are ignored while chip select is high.
// - Chip select rising moves the data byte into the addressed input register.
// - Chip select never gates the load strobe.
// - Each serial clock rising edge with chip select low and the data pin not floating shifts one bit in.
// - Bits arrive most significant first and enter the shift register in that order.
// - A floating serial data pin puts the device in hardware power down.
// - Power down leaves the stored DAC register values unchanged.
// - In power down each affected channel output is released, not driven.
// - Word layout: bit 11 all off, bit 10 one off, bits 9-8 address, 7-0 data.
// - Address 00 picks channel A, 01 B, 10 C, 11 D.
// - Only the last twelve bits shifted in count when chip select rises.
// - Low all-off bit shuts every channel; low one-off bit shuts the addressed one.
package qdc_pkg;

  localparam int CHAN_COUNT = 4;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 2;
  localparam int WORD_W = 12;

  typedef logic [DATA_W-1:0] qdc_byte_t;
  typedef qdc_byte_t [CHAN_COUNT-1:0] qdc_codes_t;
  typedef logic [ADDR_W-1:0] qdc_addr_t;

  // Field order follows the serial order, most significant bit first.
  typedef struct packed {
    logic allChannelOffBit;
    logic oneChannelOffBit;
    logic channelSelectHi;
    logic channelSelectLo;
    qdc_byte_t data;
  } qdc_word_t;

  typedef struct packed {
    logic chipSelectN;
    logic serialClock;
    logic serialData;
    logic pinFloating;
    logic loadStrobeN;
    logic clearN;
  } qdc_pins_t;

  localparam qdc_byte_t ZERO_CODE = 8'h00;
  localparam qdc_codes_t ZERO_CODES = '0;
  localparam qdc_word_t SHIFT_RESET = '0;
  localparam logic OFF_ACTIVE = 1'b0;
  localparam logic [CHAN_COUNT-1:0] ALL_CHANNELS = 4'hf;
  localparam logic [CHAN_COUNT-1:0] NO_CHANNELS = 4'h0;
  localparam qdc_pins_t PINS_IDLE = '{
    chipSelectN: 1'b1,
    serialClock: 1'b0,
    serialData: 1'b1,
    pinFloating: 1'b0,
    loadStrobeN: 1'b1,
    clearN: 1'b1
  };

  function automatic logic chanHit(input qdc_addr_t sel, input int idx);
    chanHit = (sel == idx[ADDR_W-1:0]);
  endfunction

endpackage

// ==== qdc_serial_load_monitor.sv ====
`timescale 1ns/100ps
module qdc_serial_load_monitor (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic chipSelectN,
  input wire logic serialPinFloating,
  input wire logic dacLoadStrobeN,
  input wire logic registerClearN,
  input wire qdc_pkg::qdc_codes_t dacCode,
  input wire logic [3:0] channelOutEnable,
  input wire logic hardwarePowerDown
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_reset_zero: assert property ($rose(rst_b) |-> !dacCode) else $error("rst");
  a_clear_zero: assert property (!registerClearN [*4] |=> !dacCode) else $error("clr");
  a_code_held: assert property ((dacLoadStrobeN && registerClearN) [*6]
    |=> $stable(dacCode)) else $error("code");
  a_pd_on: assert property (serialPinFloating [*4] |=> hardwarePowerDown)
    else $error("pd");
  a_pd_off: assert property (!serialPinFloating [*4] |=> !hardwarePowerDown)
    else $error("pd");
  a_pd_open: assert property (hardwarePowerDown |-> !channelOutEnable) else $error("en");
  a_pd_keeps: assert property ($changed(hardwarePowerDown) && dacLoadStrobeN
    |-> $stable(dacCode)) else $error("kept");
  a_en_held: assert property ((chipSelectN && !serialPinFloating) [*6]
    |=> $stable(channelOutEnable)) else $error("en");
  c_load: cover property (!chipSelectN && !dacLoadStrobeN);
  c_clear: cover property (!registerClearN);
  c_pd: cover property (hardwarePowerDown);
endmodule
bind qdc_serial_load qdc_serial_load_monitor mon_u (.*);

// ==== qdc_host_model.sv ====
`timescale 1ns/100ps
module qdc_host_model (
  input wire logic ref_clk,
  output logic chipSelectN = 1'h1,
  output logic serialClock = 1'h0,
  output logic serialInPowerDownPin = 1'h0
);
  logic active = 1'b0;
  // A deselected line keeps no level, so it toggles; a running send owns the line alone.
  always @(posedge ref_clk)
    if (chipSelectN && !active) serialInPowerDownPin <= !serialInPowerDownPin;
  task automatic send(input logic [15:0] w, input int n);
    active = 1'b1;
    for (int i = n; i >= 0; i--)
    begin
      repeat (16) @(posedge ref_clk);
      {chipSelectN, serialClock, serialInPowerDownPin} <= {i == 0, 1'h0, i ? w[i - 1] : 1'h0};
      repeat (16) @(posedge ref_clk);
      serialClock <= i != 0;
    end
    active = 1'b0;
  endtask
endmodule

// ==== testbench.sv ====
`timescale 1ns/100ps
module testbench;
  logic ref_clk = 1'h0, rst_b = 1'h0, dacLoadStrobeN = 1'h1, registerClearN = 1'h1;
  logic chipSelectN, serialClock, serialInPowerDownPin, hardwarePowerDown;
  logic serialPinFloating = 1'h0;
  logic [3:0] channelOutEnable;
  qdc_pkg::qdc_codes_t dacCode;
  int err_count = 0, cmp_count = 0;
  logic [51:0] row [6] = '{52'h5c1200000012f, 52'h9d3400003412f, 52'h6e5600563412f,
    52'hf378785634120, 52'h099a78569a12d, 52'h3fabab569a12f};
  qdc_serial_load dut_u (.*);
  qdc_host_model host_u (.*);
  always #2.5 ref_clk = ~ref_clk;
  task automatic chk(input string s, input logic [31:0] e, g);
    cmp_count++;
    err_count += int'(g !== e);
    if (g !== e) $display("MISMATCH %s expected %h seen %h", s, e, g);
  endtask
  // Strobe, clear and float move together, then settle past the pin synchronizers.
  task automatic pins(input logic [2:0] v);
    {dacLoadStrobeN, registerClearN, serialPinFloating} <= v;
    repeat (6) @(posedge ref_clk);
  endtask
  task automatic conclude(input int extra);
    err_count += extra;
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial #200us conclude(1);
  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'h1;
    pins(3'h6);
    chk("rst code", 32'h0, dacCode);
    chk("rst en", 4'hf, channelOutEnable);
    chk("rst pd", 1'h0, hardwarePowerDown);
    foreach (row[i])
    begin
      host_u.send(row[i][51:36], 16);
      pins(3'h6);
      chk("en", row[i][3:0], channelOutEnable);
      pins(3'h2);
      pins(3'h6);
      chk("code", row[i][35:4], dacCode);
    end
    pins(3'h2);
    host_u.send(16'h0cd7, 16);
    pins(3'h2);
    chk("follow", 32'hab569ad7, dacCode);
    pins(3'h0);
    pins(3'h2);
    host_u.send(16'h000e, 4);
    pins(3'h2);
    chk("kept", 32'h00007e00, dacCode);
    pins(3'h7);
    chk("open", 0, channelOutEnable);
    chk("pd on", 1'h1, hardwarePowerDown);
    chk("pd code", 32'h00007e00, dacCode);
    pins(3'h6);
    chk("on", 4'hf, channelOutEnable);
    chk("pd off", 1'h0, hardwarePowerDown);
    chk("pd kept", 32'h00007e00, dacCode);
    conclude(0);
  end
endmodule
